/* File: dv/tb_top.sv */
// Self-checking testbench for the deep-sleep clock gating block
`timescale 1ns/1ps
module tb_top;
  import dscg_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  strb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ags = 1'b0, slp = 1'b0, dsl = 1'b0;
  logic [6:0]  ua = 7'h00;
  logic [6:0]  uclk, uon, ufault, stat, a, on;
  logic [33:0] ex;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] vals[3];
  logic [11:0] offs[3] = '{DSCG_RUN_OFF, DSCG_SLEEP_OFF, DSCG_DEEP_OFF};
  int          pos[7] = '{0, 4, 12, 16, 17, 18, 24};
  int          n_mismatch = 0;
  int          compares = 0;

  dscg_ctrl i_dscg_ctrl (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .auto_gating_select(ags), .sleep_mode(slp), .deep_sleep_mode(dsl),
    .unit_access(ua), .unit_clk(uclk), .unit_clk_on(uon), .unit_bus_fault(ufault),
    .irq(irq));

  initial forever #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic note(string n, logic ok, logic [31:0] e, logic [31:0] g);
    compares++;
    if (!ok)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : note
  task automatic chk_data(string n, logic [31:0] e, logic [31:0] g);
    note(n, e === g, e, g);
  endtask : chk_data
  task automatic chk_resp(string n, logic [1:0] e, logic [1:0] g);
    note(n, e === g, 32'(e), 32'(g));
  endtask : chk_resp
  task automatic chk_unit(string n, logic [6:0] e, logic [6:0] g);
    note(n, e === g, 32'(e), 32'(g));
  endtask : chk_unit
  function automatic logic [6:0] on_of(logic [31:0] r);
    for (int i = 0; i < 7; i++) on_of[i] = r[pos[i]];
  endfunction : on_of

  // Response watcher: compares each answer with the oldest expectation
  always @(negedge clk)
  begin
    if (rvalid && rready && rq.size() > 0)
    begin
      ex = rq.pop_front();
      chk_data("rdata", ex[31:0], rdata);
      chk_resp("rresp", ex[33:32], rresp);
    end
    if (bvalid && bready && bq.size() > 0)
      chk_resp("bresp", bq.pop_front(), bresp);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(logic [11:0] ad, logic [31:0] d, logic [1:0] er = DSCG_RESP_OKAY);
    logic pa, pw, ta, tw;
    bq.push_back(er);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge clk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(logic [11:0] ad, logic [31:0] e, logic [1:0] er = DSCG_RESP_OKAY);
    rq.push_back({er, e});
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    void'($urandom(84559));
    stat = 7'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) rd(offs[k], 32'h0);
    @(negedge clk);
    chk_unit("clk_on", 7'h00, uon);
    $display("Test reset done");
    // Layout of all three gating registers, reserved bits and unmapped places
    for (int k = 0; k < 3; k++)
    begin
      wr(offs[k], 32'hffffffff);
      rd(offs[k], DSCG_GATE_MASK);
      vals[k] = $urandom();
      wr(offs[k], vals[k]);
      rd(offs[k], vals[k] & DSCG_GATE_MASK);
    end
    // Byte lane write: only the low byte of the deep-sleep register changes
    strb <= 4'h1;
    wr(DSCG_DEEP_OFF, 32'hffffffff);
    strb <= 4'hf;
    vals[2] = (vals[2] & 32'hffff_ff00) | 32'h0000_00ff;
    rd(DSCG_DEEP_OFF, vals[2] & DSCG_GATE_MASK);
    wr(12'h200, 32'h0, DSCG_RESP_SLV);
    rd(12'h200, 32'h0, DSCG_RESP_SLV);
    rd(DSCG_CLR_OFF, 32'h0);
    $display("Test map done");
    // Every mode combination: selection, gated clocks and faults
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk);
      ags <= m[2];
      slp <= m[1];
      dsl <= m[0];
      @(posedge clk);
      @(negedge clk);
      on = on_of(m[2] && m[0] ? vals[2] : m[2] && m[1] ? vals[1] : vals[0]);
      chk_unit("clk_on", on, uon);
      @(posedge clk);
      #2;
      chk_unit("unit_clk high", on, uclk);
      @(negedge clk);
      #2;
      chk_unit("unit_clk low", 7'h00, uclk);
      @(posedge clk);
      a = 7'($urandom());
      ua <= a;
      @(posedge clk);
      ua <= 7'h00;
      @(negedge clk);
      chk_unit("bus_fault", a & ~on, ufault);
      stat = stat | (a & ~on);
    end
    $display("Test modes done");
    // Interrupt: sticky status, read-only status, enable mask and clear
    rd(DSCG_STAT_OFF, {25'h0, stat});
    wr(DSCG_STAT_OFF, 32'h0);
    rd(DSCG_STAT_OFF, {25'h0, stat});
    @(negedge clk);
    chk_unit("irq off", 7'h00, {6'h00, irq});
    wr(DSCG_ENA_OFF, 32'h7f);
    @(negedge clk);
    chk_unit("irq on", {6'h00, |stat}, {6'h00, irq});
    wr(DSCG_CLR_OFF, {25'h0, stat});
    rd(DSCG_STAT_OFF, 32'h0);
    @(negedge clk);
    chk_unit("irq clear", 7'h00, {6'h00, irq});
    $display("Test interrupt done");
    // Reset in mid-run clears every gating register again
    wr(DSCG_DEEP_OFF, 32'hffffffff);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) rd(offs[k], 32'h0);
    @(negedge clk);
    chk_unit("clk_on after reset", 7'h00, uon);
    $display("Test mid-run reset done");
    complete_run();
  end
endmodule : tb_top

/* File: rtl/dscg_clk_gate.sv */
// Glitch-free clock gate for one unit
`timescale 1ns/1ps
module dscg_clk_gate
  import dscg_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Enable and gated clock
  input  wire logic en,
  output logic      gclk
);

  logic en_low_r;

  // Outside reset, enable changes only while clk is low, so no pulse is cut short
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      en_low_r <= 1'b0;
    else
      en_low_r <= en;
  end

  assign gclk = clk & en_low_r;

endmodule : dscg_clk_gate

/* File: rtl/dscg_ctrl.sv */
// Deep-sleep clock gating control with AXI4-Lite registers, unit clock gates and fault reporting
//
// Functional notes
// - A set gating bit delivers a running clock to its unit.
// - A cleared gating bit stops the unit clock, keeping it disabled.
// - Any access to an unclocked unit is answered with a bus fault.
// - All gating bits are zero after reset, so units start unclocked.
// - Register resets to zero; implemented gating fields are read/write.
// - Run, sleep and deep-sleep gating registers share one layout.
// - Sleep and deep-sleep registers apply only while auto gating is selected.
// - Deep-sleep gating register sits at offset 0x124.
// - Bit 24 comparator; bits 18, 17, 16 timers two, one, zero.
// - Bit 12 two-wire port, bit 4 sync serial, bit 0 async serial.
// - Reserved bits read zero; software preserves them on updates.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dscg_ctrl
  import dscg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power mode
  input  wire logic        auto_gating_select,
  input  wire logic        sleep_mode,
  input  wire logic        deep_sleep_mode,
  // Units: index 0 async, 1 sync, 2 two-wire, 3..5 timers 0..2, 6 comparator
  input  wire logic [6:0]  unit_access,
  output logic [6:0]       unit_clk,
  output logic [6:0]       unit_clk_on,
  output logic [6:0]       unit_bus_fault,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of each unit in the gating layout

  localparam int unsigned UNIT_POS [DSCG_UNITS] = '{DSCG_ASYNC_BIT, DSCG_SYNC_BIT,
    DSCG_TWI_BIT, DSCG_T0_BIT, DSCG_T1_BIT, DSCG_T2_BIT, DSCG_CMP_BIT};

  logic [31:0] run_r;
  logic [31:0] sleep_r;
  logic [31:0] deep_r;
  logic [6:0]  stat_r;
  logic [6:0]  ena_r;
  logic [6:0]  fault_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order

  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire         aw_fire  = s_axi_awvalid & s_axi_awready;
  wire         w_fire   = s_axi_wvalid & s_axi_wready;
  wire         aw_have  = aw_held_r | aw_fire;
  wire         w_have   = w_held_r | w_fire;
  wire         wr_fire  = aw_have & w_have & ~bvalid_r;
  wire [11:0]  wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0]  wr_data  = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held_r ? wstrb_r : s_axi_wstrb;
  wire [31:0]  wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
                           {8{wr_strb[0]}}};

  wire         wr_run   = wr_fire & (wr_addr == DSCG_RUN_OFF);
  wire         wr_sleep = wr_fire & (wr_addr == DSCG_SLEEP_OFF);
  wire         wr_deep  = wr_fire & (wr_addr == DSCG_DEEP_OFF);
  wire         wr_ena   = wr_fire & (wr_addr == DSCG_ENA_OFF);
  wire         wr_clr   = wr_fire & (wr_addr == DSCG_CLR_OFF);
  wire         wr_hit   = wr_run | wr_sleep | wr_deep | wr_ena | wr_clr |
                          (wr_fire & (wr_addr == DSCG_STAT_OFF));

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      aw_held_r <= aw_have & ~wr_fire;
      w_held_r  <= w_have & ~wr_fire;
      if (aw_fire)
        awaddr_r <= s_axi_awaddr;
      if (w_fire)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= DSCG_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? DSCG_RESP_OKAY : DSCG_RESP_SLV;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gating registers: one layout for run, sleep and deep sleep

  function automatic logic [31:0] merge_gate(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] bmask);
    merge_gate = ((old_v & ~bmask) | (new_v & bmask)) & DSCG_GATE_MASK;
  endfunction : merge_gate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      run_r   <= DSCG_GATE_RST;
      sleep_r <= DSCG_GATE_RST;
      deep_r  <= DSCG_GATE_RST;
    end
    else
    begin
      if (wr_run)
        run_r <= merge_gate(run_r, wr_data, wr_bmask);
      if (wr_sleep)
        sleep_r <= merge_gate(sleep_r, wr_data, wr_bmask);
      if (wr_deep)
        deep_r <= merge_gate(deep_r, wr_data, wr_bmask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select the active register and gate the unit clocks

  wire [31:0] active_gate = (auto_gating_select & deep_sleep_mode) ? deep_r :
                            (auto_gating_select & sleep_mode)      ? sleep_r :
                            run_r;

  for (genvar i = 0; i < DSCG_UNITS; i++)
  begin : g_unit
    assign unit_clk_on[i] = active_gate[UNIT_POS[i]];
    dscg_clk_gate u_gate (
      .clk  (clk),
      .rst  (rst),
      .en   (unit_clk_on[i]),
      .gclk (unit_clk[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus faults for accesses to unclocked units, and the interrupt

  wire [6:0] fault_evt = unit_access & ~unit_clk_on;

  assign unit_bus_fault = fault_r;
  assign irq            = |(stat_r & ena_r);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_r <= DSCG_IRQ_RST;
      stat_r  <= DSCG_IRQ_RST;
      ena_r   <= DSCG_IRQ_RST;
    end
    else
    begin
      fault_r <= fault_evt;
      if (wr_ena)
        ena_r <= wr_strb[0] ? wr_data[6:0] : ena_r;
      // A new event wins over a simultaneous clear
      stat_r <= (stat_r & ~((wr_clr & wr_strb[0]) ? wr_data[6:0] : 7'h00)) | fault_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire         rd_fire = s_axi_arvalid & s_axi_arready;
  wire         rd_map  = (s_axi_araddr == DSCG_RUN_OFF) | (s_axi_araddr == DSCG_SLEEP_OFF) |
                         (s_axi_araddr == DSCG_DEEP_OFF) | (s_axi_araddr == DSCG_STAT_OFF) |
                         (s_axi_araddr == DSCG_ENA_OFF) | (s_axi_araddr == DSCG_CLR_OFF);
  wire [31:0]  rd_mux  = (s_axi_araddr == DSCG_RUN_OFF)   ? run_r :
                         (s_axi_araddr == DSCG_SLEEP_OFF) ? sleep_r :
                         (s_axi_araddr == DSCG_DEEP_OFF)  ? deep_r :
                         (s_axi_araddr == DSCG_STAT_OFF)  ? {25'h0, stat_r} :
                         (s_axi_araddr == DSCG_ENA_OFF)   ? {25'h0, ena_r} :
                         32'h0000_0000;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= DSCG_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_map ? DSCG_RESP_OKAY : DSCG_RESP_SLV;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    ((deep_r | run_r | sleep_r) & ~DSCG_GATE_MASK) == 32'h0000_0000)
    else $error("reserved gating bit set");

  reset_clear_a: assert property (@(posedge clk)
    $fell(rst) |-> (deep_r == DSCG_GATE_RST) && (run_r == DSCG_GATE_RST) &&
      (sleep_r == DSCG_GATE_RST) && (unit_clk_on == 7'h00))
    else $error("gating register not zero after reset");

  fault_gated_a: assert property (@(posedge clk) disable iff (rst)
    (unit_access & ~unit_clk_on) != 7'h00 |=> unit_bus_fault == $past(fault_evt))
    else $error("missing bus fault for unclocked unit");

  no_fault_on_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (unit_bus_fault & $past(unit_clk_on)) == 7'h00)
    else $error("bus fault on clocked unit");

  deep_select_a: assert property (@(posedge clk) disable iff (rst)
    auto_gating_select && deep_sleep_mode |->
      unit_clk_on == {deep_r[24], deep_r[18:16], deep_r[12], deep_r[4], deep_r[0]})
    else $error("deep sleep selection wrong");

  run_select_a: assert property (@(posedge clk) disable iff (rst)
    !auto_gating_select |->
      unit_clk_on == {run_r[24], run_r[18:16], run_r[12], run_r[4], run_r[0]})
    else $error("run selection wrong without auto gating");

  deep_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_deep && wr_strb == 4'hf |=> deep_r == ($past(wr_data) & DSCG_GATE_MASK))
    else $error("deep gating write not stored");

  write_resp_a: assert property (@(posedge clk) disable iff (rst)
    wr_fire |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_hit) ? DSCG_RESP_OKAY : DSCG_RESP_SLV)))
    else $error("write response missing");

  gate_off_a: assert property (@(posedge clk) disable iff (rst)
    !unit_clk_on[0] |-> !g_unit[0].u_gate.en_low_r)
    else $error("gated clock still enabled");

  irq_sticky_a: assert property (@(posedge clk) disable iff (rst)
    fault_evt != 7'h00 |=> (stat_r & $past(fault_evt)) == $past(fault_evt))
    else $error("fault event lost from status");

endmodule : dscg_ctrl

/* File: rtl/dscg_pkg.sv */
// Package: register map, field layout and reset values of the deep-sleep gating block
package dscg_pkg;

  localparam int unsigned DSCG_UNITS = 7;

  // Register byte offsets
  localparam logic [11:0] DSCG_RUN_OFF    = 12'h104;
  localparam logic [11:0] DSCG_SLEEP_OFF  = 12'h114;
  localparam logic [11:0] DSCG_DEEP_OFF   = 12'h124;
  localparam logic [11:0] DSCG_STAT_OFF   = 12'h130;
  localparam logic [11:0] DSCG_ENA_OFF    = 12'h134;
  localparam logic [11:0] DSCG_CLR_OFF    = 12'h138;

  // Gating field positions
  localparam int unsigned DSCG_ASYNC_BIT  = 0;
  localparam int unsigned DSCG_SYNC_BIT   = 4;
  localparam int unsigned DSCG_TWI_BIT    = 12;
  localparam int unsigned DSCG_T0_BIT     = 16;
  localparam int unsigned DSCG_T1_BIT     = 17;
  localparam int unsigned DSCG_T2_BIT     = 18;
  localparam int unsigned DSCG_CMP_BIT    = 24;

  // Implemented gating bits; everything else reads as zero
  localparam logic [31:0] DSCG_GATE_MASK  = 32'h0107_1011;
  localparam logic [31:0] DSCG_GATE_RST   = 32'h0000_0000;
  localparam logic [6:0]  DSCG_IRQ_RST    = 7'h00;

  // Bus responses
  localparam logic [1:0]  DSCG_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  DSCG_RESP_SLV   = 2'h2;

endpackage : dscg_pkg
